// *** rtl/solo_mode_control_logic.sv ***
`timescale 1ns/1ns
`include "solo_ctrl_cfg.svh"

// How it works
// RULE_01: With no listen mode selected the listen solo is after-fader.
// RULE_02: Mode outputs only act while some channel or return solo is engaged; the code drives tap and stereo from the mode bits at all times.
// RULE_03: Listen modes swap solo bus for monitor source and mute nothing.
// RULE_04: After-fader listen taps after the pan control, in stereo.
// RULE_05: Pre-fader listen taps after insert, before fader, mono, for every solo.
// RULE_06: Early pre-fader listen taps after preamp and compressor, before EQ, mono.
// RULE_07: In-place solo mutes every unsoloed channel and return, heard via program buses.
// RULE_08: In-place solo is enabled per fader path by its own control bit.
// RULE_09: Linked in-place: any solo mutes unsoloed unsafed faders on both paths.
// RULE_10: Unlinked in-place mutes only the path holding an in-place solo.
// RULE_11: Mix-over-solo only with listen solos, never with in-place solos.
// RULE_12: Mix-over-solo needs its enable and some channel or return solo.
// RULE_13: Auxiliary master listen is always after-fader, via its own button; the code gives it the tap selected by the mode bits.
// RULE_14: Release-all press clears channel solos, not latching, keeps auxiliary listens.
// RULE_15: Release-all lamp flashes while any channel or auxiliary solo is active.
// RULE_16: Hold mode: solo follows its held button, several at once.
// RULE_17: Additive mode: each press toggles its solo, any number stay engaged.
// RULE_18: Latch mode: one solo at most, second press of it releases.
// RULE_19: Latch mode: another button releases current solo and engages new one.
// RULE_20: Button modes are exclusive; early pre-fader listen beats pre-fader listen.
module solo_mode_control_logic #(
    parameter int          N_CH            = 16,
    parameter int          N_AUX           = 3,
    parameter int unsigned FLASH_HALF_CYC  = `SOLO_FLASH_HALF_CYC
) (
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_arst_n,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic [31:0]                hwdata,
    input  wire logic                       hsel,
    input  wire logic                       hready,
    output logic      [31:0]                hrdata,
    output logic                            hreadyout,
    output logic                            hresp,
    input  wire logic [N_CH-1:0]            i_small_solo_btn,
    input  wire logic [N_CH-1:0]            i_large_solo_btn,
    input  wire logic [N_AUX-1:0]           i_aux_listen_btn,
    input  wire logic                       i_solo_release_all_btn,
    output logic      [N_CH-1:0]            o_small_solo,
    output logic      [N_CH-1:0]            o_large_solo,
    output logic      [N_AUX-1:0]           o_aux_listen,
    output logic      [N_CH-1:0]            o_small_mute,
    output logic      [N_CH-1:0]            o_large_mute,
    output solo_ctrl_pkg::solo_route_t      o_route,
    output solo_ctrl_pkg::in_place_t        o_in_place,
    output logic                            o_release_all_lamp
);

    // Solo index space: small path in the low half, large path in the high half.
    localparam int NB = 2 * N_CH;
    // The flash counter is wide enough for the whole half period.
    localparam int FW = $clog2(FLASH_HALF_CYC + 1);

    logic [`SOLO_CTRL_W-1:0]     ctrl_reg;
    logic [N_CH-1:0]             safe_reg;
    logic [NB-1:0]               solo_reg;
    logic [NB-1:0]               solo_next;
    logic [N_AUX-1:0]            aux_reg;
    logic [NB+N_AUX:0]           btn_meta_reg;
    logic [NB+N_AUX:0]           btn_sync_reg;
    logic [NB+N_AUX:0]           btn_prev_reg;
    logic [NB+N_AUX:0]           btn_press;
    logic [NB-1:0]               ch_held;
    logic [NB-1:0]               ch_press;
    logic [NB-1:0]               latch_pick;
    logic                        release_press;
    logic [FW-1:0]               flash_cnt_reg;
    logic                        flash_reg;
    solo_ctrl_pkg::btn_mode_t    btn_mode;
    solo_ctrl_pkg::btn_mode_t    btn_mode_reg;
    logic                        any_small;
    logic                        any_large;
    logic                        any_ch_solo;
    logic                        any_aux;
    logic                        ip_small;
    logic                        ip_large;
    logic                        listen_solo;
    logic                        mute_small_path;
    logic                        mute_large_path;
    logic                        ap_valid_reg;
    logic                        ap_write_reg;
    logic [7:0]                  ap_addr_reg;
    logic [31:0]                 status_word;
    logic [31:0]                 solos_word;

    // Buttons come from pins, so every one passes two flops first.
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            btn_meta_reg <= '0;
            btn_sync_reg <= '0;
            btn_prev_reg <= '0;
        end else begin
            btn_meta_reg <= {i_solo_release_all_btn, i_aux_listen_btn, i_large_solo_btn, i_small_solo_btn};
            btn_sync_reg <= btn_meta_reg;
            btn_prev_reg <= btn_sync_reg;
        end
    end

    // A press is the first cycle in which a synchronised button reads high.
    assign btn_press     = btn_sync_reg & ~btn_prev_reg;
    assign ch_held       = btn_sync_reg[NB-1:0];
    assign ch_press      = btn_press[NB-1:0];
    assign release_press = btn_press[NB+N_AUX];

    // An illegal code of the mode field falls back to hold mode.
    always_comb begin
        unique case (ctrl_reg[`SOLO_CTRL_BTN_HI:`SOLO_CTRL_BTN_LO])
            2'h1:    btn_mode = solo_ctrl_pkg::BTN_ADDITIVE; // RULE_20
            2'h2:    btn_mode = solo_ctrl_pkg::BTN_LATCH; // RULE_20
            default: btn_mode = solo_ctrl_pkg::BTN_HOLD; // RULE_20
        endcase
    end

    // Lowest pressed index wins when several are pressed in one cycle.
    always_comb begin
        latch_pick = '0;
        for (int i = NB - 1; i >= 0; i--) begin
            if (ch_press[i]) begin
                latch_pick = '0;
                latch_pick[i] = 1'b1;
            end
        end
    end

    // A press in the same cycle as a release-all still engages its solo.
    always_comb begin
        solo_next = release_press ? '0 : solo_reg; // RULE_14
        unique case (btn_mode)
            solo_ctrl_pkg::BTN_HOLD: begin
                solo_next = ch_held; // RULE_16
            end
            solo_ctrl_pkg::BTN_ADDITIVE: begin
                solo_next = solo_next ^ ch_press; // RULE_17
            end
            solo_ctrl_pkg::BTN_LATCH: begin
                if (|ch_press) begin
                    if (|(latch_pick & solo_next)) begin
                        solo_next = '0; // RULE_18
                    end else begin
                        solo_next = latch_pick; // RULE_19
                    end
                end
            end
        endcase
    end

    // The previous mode lets a mode change be seen one cycle later.
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            btn_mode_reg <= solo_ctrl_pkg::BTN_HOLD;
        end else begin
            btn_mode_reg <= btn_mode;
        end
    end

    // Changing button mode drops latched solos so no stale set survives.
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            solo_reg <= '0;
        end else if (btn_mode != btn_mode_reg) begin
            solo_reg <= '0;
        end else begin
            solo_reg <= solo_next;
        end
    end

    // Auxiliary listens toggle and ignore release-all.
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            aux_reg <= '0;
        end else begin
            aux_reg <= aux_reg ^ btn_press[NB+N_AUX-1:NB]; // RULE_13 RULE_14
        end
    end

    // Summary flags of the engaged solos, per path and for the auxiliary masters.
    assign any_small   = |solo_reg[N_CH-1:0];
    assign any_large   = |solo_reg[NB-1:N_CH];
    assign any_ch_solo = any_small | any_large;
    assign any_aux     = |aux_reg;

    // In-place acts on a path only while its enable bit is set and it holds a solo.
    assign ip_small = ctrl_reg[`SOLO_CTRL_IN_PLACE_SMALL] & any_small; // RULE_08 RULE_02
    assign ip_large = ctrl_reg[`SOLO_CTRL_IN_PLACE_LARGE] & any_large; // RULE_08 RULE_02

    // Listen solos are those on a path without in-place enabled.
    assign listen_solo = (any_small & ~ctrl_reg[`SOLO_CTRL_IN_PLACE_SMALL])
                       | (any_large & ~ctrl_reg[`SOLO_CTRL_IN_PLACE_LARGE]); // RULE_03

    // A path mutes when it holds an in-place solo, or when linked to one that does.
    assign mute_small_path = ip_small | (ctrl_reg[`SOLO_CTRL_LINK] & ip_large); // RULE_09 RULE_10
    assign mute_large_path = ip_large | (ctrl_reg[`SOLO_CTRL_LINK] & ip_small); // RULE_09 RULE_10

    // Safed channels never mute on either path; soloed faders never mute on their own path.
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_small_mute <= '0;
            o_large_mute <= '0;
        end else begin
            o_small_mute <= {N_CH{mute_small_path}} & ~solo_reg[N_CH-1:0] & ~safe_reg; // RULE_07
            o_large_mute <= {N_CH{mute_large_path}} & ~solo_reg[NB-1:N_CH] & ~safe_reg; // RULE_07
        end
    end

    // Tap and stereo follow the mode bits even with no solo engaged.
    // Only the solo bus choice and the mix gate wait for a solo.
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_route <= '{use_solo_bus: 1'b0, mix_over_active: 1'b0, stereo: 1'b1,
                         tap: solo_ctrl_pkg::TAP_POST_PAN};
        end else begin
            o_route.use_solo_bus    <= listen_solo | any_aux; // RULE_03 RULE_13
            o_route.mix_over_active <= ctrl_reg[`SOLO_CTRL_MIX_OVER] & listen_solo; // RULE_11 RULE_12
            if (ctrl_reg[`SOLO_CTRL_PREFADER_EARLY]) begin
                o_route.tap    <= solo_ctrl_pkg::TAP_POST_PREAMP; // RULE_06 RULE_20
                o_route.stereo <= 1'b0;
            end else if (ctrl_reg[`SOLO_CTRL_PREFADER]) begin
                o_route.tap    <= solo_ctrl_pkg::TAP_POST_INSERT; // RULE_05
                o_route.stereo <= 1'b0;
            end else begin
                o_route.tap    <= solo_ctrl_pkg::TAP_POST_PAN; // RULE_01 RULE_04
                o_route.stereo <= 1'b1;
            end
        end
    end

    // In-place state tells the audio side which paths are destructive.
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_in_place <= '0;
        end else begin
            o_in_place.small_active <= ip_small; // RULE_07
            o_in_place.large_active <= ip_large; // RULE_07
            o_in_place.linked       <= ctrl_reg[`SOLO_CTRL_LINK] & (ip_small | ip_large); // RULE_09
        end
    end

    // Lamp blink timebase.
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            flash_cnt_reg <= '0;
            flash_reg     <= 1'b0;
        end else if (flash_cnt_reg == FW'(FLASH_HALF_CYC - 1)) begin
            flash_cnt_reg <= '0;
            flash_reg     <= ~flash_reg;
        end else begin
            flash_cnt_reg <= flash_cnt_reg + 1'b1;
        end
    end

    // The flash is gated here, so the timebase itself never stops.
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_release_all_lamp <= 1'b0;
        end else begin
            o_release_all_lamp <= (any_ch_solo | any_aux) & flash_reg; // RULE_15
        end
    end

    // Solo states leave the block straight from their register.
    assign o_small_solo = solo_reg[N_CH-1:0];
    assign o_large_solo = solo_reg[NB-1:N_CH];
    assign o_aux_listen = aux_reg;

    // AHB-Lite slave: zero wait states, always OKAY.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // The address phase is captured only while the bus is ready.
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ap_valid_reg <= 1'b0;
            ap_write_reg <= 1'b0;
            ap_addr_reg  <= '0;
        end else if (hready) begin
            ap_valid_reg <= hsel & htrans[1];
            ap_write_reg <= hwrite;
            ap_addr_reg  <= haddr[7:0];
        end
    end

    // Writes land at the end of the data phase; other offsets are ignored.
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_reg <= `SOLO_CTRL_RST;
            safe_reg <= N_CH'(`SOLO_SAFE_RST);
        end else if (ap_valid_reg && ap_write_reg) begin
            if (ap_addr_reg == `SOLO_OFS_CTRL) begin
                ctrl_reg <= hwdata[`SOLO_CTRL_W-1:0];
            end
            if (ap_addr_reg == `SOLO_OFS_SAFE) begin
                safe_reg <= hwdata[N_CH-1:0];
            end
        end
    end

    // Read views of the solo set and of the current routing.
    always_comb begin
        solos_word = '0;
        solos_word[NB-1:0] = solo_reg;
        status_word = '0;
        status_word[`SOLO_STAT_AUX_LO +: N_AUX] = aux_reg;
        status_word[`SOLO_STAT_MON]      = o_route.use_solo_bus;
        status_word[`SOLO_STAT_MIX]      = o_route.mix_over_active;
        status_word[`SOLO_STAT_STEREO]   = o_route.stereo;
        status_word[`SOLO_STAT_TAP_HI:`SOLO_STAT_TAP_LO] = o_route.tap;
        status_word[`SOLO_STAT_IP_SMALL] = o_in_place.small_active;
        status_word[`SOLO_STAT_IP_LARGE] = o_in_place.large_active;
        status_word[`SOLO_STAT_ANY]      = any_ch_solo;
    end

    // Read data is registered at the address phase and held until the next read.
    // Only the low address byte is decoded, so higher address bits alias.
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hrdata <= '0;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            unique case (haddr[7:0])
                `SOLO_OFS_CTRL:   hrdata <= 32'(ctrl_reg);
                `SOLO_OFS_SAFE:   hrdata <= 32'(safe_reg);
                `SOLO_OFS_SOLOS:  hrdata <= solos_word;
                `SOLO_OFS_STATUS: hrdata <= status_word;
                default:          hrdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule

// *** shared/solo_ctrl_cfg.svh ***
`ifndef SOLO_CTRL_CFG_SVH
`define SOLO_CTRL_CFG_SVH

// Register byte offsets.
`define SOLO_OFS_CTRL        8'h00
`define SOLO_OFS_SAFE        8'h04
`define SOLO_OFS_SOLOS       8'h08
`define SOLO_OFS_STATUS      8'h0C

// Control register field positions.
`define SOLO_CTRL_PREFADER        0
`define SOLO_CTRL_PREFADER_EARLY  1
`define SOLO_CTRL_IN_PLACE_SMALL  2
`define SOLO_CTRL_IN_PLACE_LARGE  3
`define SOLO_CTRL_LINK       4
`define SOLO_CTRL_MIX_OVER   5
`define SOLO_CTRL_BTN_LO     6
`define SOLO_CTRL_BTN_HI     7
`define SOLO_CTRL_W          8

// Status register field positions.
`define SOLO_STAT_AUX_LO     0
`define SOLO_STAT_MON        16
`define SOLO_STAT_MIX        17
`define SOLO_STAT_STEREO     18
`define SOLO_STAT_TAP_LO     19
`define SOLO_STAT_TAP_HI     20
`define SOLO_STAT_IP_SMALL   21
`define SOLO_STAT_IP_LARGE   22
`define SOLO_STAT_ANY        23

// Reset values.
`define SOLO_CTRL_RST        8'h00
`define SOLO_SAFE_RST        32'h0000_0000

// Lamp flash half period.
`define SOLO_CLK_HZ          10000000
`define SOLO_FLASH_HALF_MS   250
`define SOLO_FLASH_HALF_CYC  ((`SOLO_CLK_HZ / 1000) * `SOLO_FLASH_HALF_MS)

`endif

// *** shared/solo_ctrl_pkg.sv ***
package solo_ctrl_pkg;

    typedef enum logic [1:0] {
        BTN_HOLD,
        BTN_ADDITIVE,
        BTN_LATCH
    } btn_mode_t;

    typedef enum logic [1:0] {
        TAP_POST_PAN,
        TAP_POST_INSERT,
        TAP_POST_PREAMP
    } tap_t;

    typedef struct packed {
        logic      use_solo_bus;
        logic      mix_over_active;
        logic      stereo;
        tap_t      tap;
    } solo_route_t;

    typedef struct packed {
        logic      small_active;
        logic      large_active;
        logic      linked;
    } in_place_t;

endpackage

// *** verification/solo_mode_control_logic_properties.sv ***
`timescale 1ns/1ns
module solo_mode_control_logic_checker #(
    parameter int          N_CH           = 16,
    parameter int          N_AUX          = 3,
    parameter int unsigned FLASH_HALF_CYC = 4
) (
    input wire logic                       i_clk_sys,
    input wire logic                       i_arst_n,
    input wire logic                       hreadyout,
    input wire logic                       hresp,
    input wire logic [N_CH-1:0]            i_small_solo_btn,
    input wire logic [N_CH-1:0]            i_large_solo_btn,
    input wire logic                       i_solo_release_all_btn,
    input wire logic [N_CH-1:0]            o_small_solo,
    input wire logic [N_CH-1:0]            o_large_solo,
    input wire logic [N_AUX-1:0]           o_aux_listen,
    input wire logic [N_CH-1:0]            o_small_mute,
    input wire logic [N_CH-1:0]            o_large_mute,
    input wire solo_ctrl_pkg::solo_route_t o_route,
    input wire solo_ctrl_pkg::in_place_t   o_in_place,
    input wire logic                       o_release_all_lamp
);
    logic any_ch;
    logic any_solo;
    logic any_btn;
    assign any_ch = |{o_small_solo, o_large_solo};
    assign any_solo = any_ch | (|o_aux_listen);
    assign any_btn = |{i_small_solo_btn, i_large_solo_btn};
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer is not zero-wait OKAY");
    a_idle_gate: assert property (
        !$past(any_solo) |-> !o_route.use_solo_bus && !o_route.mix_over_active && o_small_mute == '0)
        else $error("solo bus, mix or mute active with no solo");
    a_lamp_dark: assert property (!any_solo [*2] |-> !o_release_all_lamp)
        else $error("release-all lamp lit with no solo");
    a_lamp_flash: assert property (
        $rose(any_solo) |-> ##[1:12] (o_release_all_lamp || !any_solo))
        else $error("release-all lamp did not light while a solo is active");
    a_mute_unsoloed: assert property (
        (o_small_mute & $past(o_small_solo)) == '0 && (o_large_mute & $past(o_large_solo)) == '0)
        else $error("a soloed fader is muted");
    a_mute_path_small: assert property (
        |o_small_mute |-> o_in_place.small_active || (o_in_place.linked && o_in_place.large_active))
        else $error("small path muted without in-place solo on it");
    a_mute_path_large: assert property (
        |o_large_mute |-> o_in_place.large_active || (o_in_place.linked && o_in_place.small_active))
        else $error("large path muted without in-place solo on it");
    a_mix_gate: assert property (
        o_route.mix_over_active |-> $past(any_ch) && o_route.use_solo_bus)
        else $error("mix-over active without a channel solo");
    a_aux_bus: assert property ($past(|o_aux_listen) |-> o_route.use_solo_bus)
        else $error("auxiliary listen does not feed the solo bus");
    a_release_clear: assert property (
        !any_btn [*3] ##1 ($rose(i_solo_release_all_btn) && !any_btn) ##1 !any_btn [*3]
        |-> ##[0:2] (o_small_solo == '0 && o_large_solo == '0))
        else $error("release-all did not clear channel solos");
    c_mute: cover property ($rose(|o_small_mute));
    c_mix: cover property ($rose(o_route.mix_over_active));
    c_aux: cover property ($rose(|o_aux_listen));
endmodule

bind solo_mode_control_logic solo_mode_control_logic_checker #(
    .N_CH(N_CH),
    .N_AUX(N_AUX),
    .FLASH_HALF_CYC(FLASH_HALF_CYC)
) u_chk (.*);

// *** verification/solo_panel_model.sv ***
`timescale 1ns/1ns
module solo_panel_model #(
    parameter int N_CH  = 16,
    parameter int N_AUX = 3
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_lamp,
    output logic      [N_CH-1:0]  o_small_btn,
    output logic      [N_CH-1:0]  o_large_btn,
    output logic      [N_AUX-1:0] o_aux_btn,
    output logic                  o_release_btn
);
    int   lamp_rises = 0;
    logic lamp_q     = 1'b0;
    initial begin
        o_small_btn = '0;
        o_large_btn = '0;
        o_aux_btn = '0;
        o_release_btn = 1'b0;
    end
    // Counts lamp flashes so the bench can see that the lamp blinks.
    always @(posedge i_clk_sys) begin
        lamp_q <= i_lamp;
        if (i_lamp && !lamp_q) begin
            lamp_rises <= lamp_rises + 1;
        end
    end
    task set_btn(input int path, input logic [31:0] v);
        case (path)
            0: o_small_btn <= v[N_CH-1:0];
            1: o_large_btn <= v[N_CH-1:0];
            2: o_aux_btn <= v[N_AUX-1:0];
            default: o_release_btn <= v[0];
        endcase
    endtask
    // A press is held long enough to pass the button synchroniser, then let go.
    task press(input int path, input int idx);
        set_btn(path, 32'h1 << idx);
        repeat (5) @(posedge i_clk_sys);
        set_btn(path, 32'h0);
        repeat (5) @(posedge i_clk_sys);
    endtask
endmodule

// *** verification/test_solo_mode_control_logic.sv ***
`timescale 1ns/1ns
module test_solo_mode_control_logic;
    localparam int N_CH = 16;
    localparam int N_AUX = 3;
    logic                       i_clk_sys = 1'b0;
    logic                       i_arst_n  = 1'b0;
    logic [31:0]                haddr     = 32'h0;
    logic [1:0]                 htrans    = 2'h0;
    logic                       hwrite    = 1'b0;
    logic [2:0]                 hsize     = 3'h2;
    logic [31:0]                hwdata    = 32'h0;
    logic                       hsel      = 1'b0;
    logic                       hready;
    logic [31:0]                hrdata;
    logic                       hreadyout;
    logic                       hresp;
    logic [N_CH-1:0]            i_small_solo_btn;
    logic [N_CH-1:0]            i_large_solo_btn;
    logic [N_AUX-1:0]           i_aux_listen_btn;
    logic                       i_solo_release_all_btn;
    logic [N_CH-1:0]            o_small_solo;
    logic [N_CH-1:0]            o_large_solo;
    logic [N_AUX-1:0]           o_aux_listen;
    logic [N_CH-1:0]            o_small_mute;
    logic [N_CH-1:0]            o_large_mute;
    solo_ctrl_pkg::solo_route_t o_route;
    solo_ctrl_pkg::in_place_t   o_in_place;
    logic                       o_release_all_lamp;
    logic [31:0]                rd;
    int                         n_mismatch = 0;
    int                         compares   = 0;
    int                         lamp_base;
    assign hready = hreadyout;
    always #50 i_clk_sys = ~i_clk_sys;
    solo_mode_control_logic #(.N_CH(N_CH), .N_AUX(N_AUX), .FLASH_HALF_CYC(4)) u_dut (.*);
    solo_panel_model #(.N_CH(N_CH), .N_AUX(N_AUX)) u_panel (
        .i_clk_sys     (i_clk_sys),
        .i_lamp        (o_release_all_lamp),
        .o_small_btn   (i_small_solo_btn),
        .o_large_btn   (i_large_solo_btn),
        .o_aux_btn     (i_aux_listen_btn),
        .o_release_btn (i_solo_release_all_btn)
    );
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        hsel <= 1'b1;
        do @(posedge i_clk_sys); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge i_clk_sys); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task settle;
        repeat (6) @(posedge i_clk_sys);
    endtask
    task final_report;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge i_clk_sys);
        n_mismatch++;
        final_report;
    end
    initial begin
        repeat (2) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        @(posedge i_clk_sys);
        ahb(1'b0, 8'h00, 32'h0);
        chk("ctrl reset", rd, 32'h0);
        ahb(1'b1, 8'h10, 32'hFFFF_FFFF);
        ahb(1'b0, 8'h10, 32'h0);
        chk("unmapped", rd, 32'h0);
        chk("route idle", o_route, 32'h04);
        $display("test registers done");
        ahb(1'b1, 8'h00, 32'h40);
        u_panel.press(0, 3);
        chk("small solo", o_small_solo, 32'h8);
        chk("route after fader", o_route, 32'h14);
        chk("mutes", {o_small_mute, o_large_mute}, 32'h0);
        u_panel.press(1, 5);
        chk("two solos", {o_large_solo, o_small_solo}, 32'h0020_0008);
        u_panel.press(0, 3);
        chk("toggle off", o_small_solo, 32'h0);
        $display("test additive done");
        for (int k = 0; k < 3; k++) begin
            ahb(1'b1, 8'h00, 32'h40 | (k + 1));
            settle;
            chk("route listen", o_route, (k == 0) ? 32'h11 : 32'h12);
        end
        ahb(1'b1, 8'h00, 32'h61);
        settle;
        chk("route mix", o_route, 32'h19);
        u_panel.press(1, 5);
        chk("mix no solo", o_route, 32'h01);
        $display("test listen done");
        ahb(1'b1, 8'h04, 32'h80);
        ahb(1'b1, 8'h00, 32'h64);
        u_panel.press(0, 2);
        chk("small mute", o_small_mute, 32'hFF7B);
        chk("large mute", o_large_mute, 32'h0);
        chk("in place", o_in_place, 32'h4);
        chk("no mix", o_route.mix_over_active, 32'h0);
        ahb(1'b1, 8'h00, 32'h74);
        settle;
        chk("linked mute", o_large_mute, 32'hFF7F);
        chk("in place linked", o_in_place, 32'h5);
        ahb(1'b1, 8'h00, 32'h48);
        settle;
        chk("large only", {o_small_mute, o_large_mute}, 32'h0);
        $display("test in place done");
        u_panel.press(2, 1);
        chk("aux", o_aux_listen, 32'h2);
        lamp_base = u_panel.lamp_rises;
        repeat (20) @(posedge i_clk_sys);
        chk("lamp", (u_panel.lamp_rises - lamp_base) >= 2, 32'h1);
        ahb(1'b0, 8'h0C, 32'h0);
        chk("status", rd, 32'h0085_0002);
        u_panel.press(3, 0);
        chk("cleared", o_small_solo, 32'h0);
        chk("aux kept", o_aux_listen, 32'h2);
        ahb(1'b0, 8'h08, 32'h0);
        chk("solos reg", rd, 32'h0);
        u_panel.press(2, 1);
        settle;
        chk("lamp dark", o_release_all_lamp, 32'h0);
        $display("test release done");
        ahb(1'b1, 8'h00, 32'h80);
        u_panel.press(0, 1);
        chk("latch", o_small_solo, 32'h2);
        u_panel.press(1, 4);
        chk("latch move", {o_large_solo, o_small_solo}, 32'h0010_0000);
        u_panel.press(1, 4);
        chk("latch off", o_large_solo, 32'h0);
        $display("test latch done");
        ahb(1'b1, 8'h00, 32'h00);
        u_panel.set_btn(0, 32'h0201);
        settle;
        chk("hold", o_small_solo, 32'h0201);
        u_panel.set_btn(0, 32'h0);
        settle;
        chk("hold off", o_small_solo, 32'h0);
        $display("test hold done");
        final_report;
    end
endmodule
